// *** logic/sddo_pkg.sv ***
package sddo_pkg;
// Behaviour
// R1: Select low decimates by eight (default).
// R2: Select high decimates by four, faster words.
// R3: One modulator sample taken per clock.
// R4: Positive overrange saturates word to 7fff.
// R5: Negative overrange saturates word to 8000.
// R6: Range flag high when input beyond full-scale.
// R7: First 47 ready cycles are unsettled.
// R8: Reset forces ready high, data low.
// R9: Host releases reset near clock falling edge; the testbench releases it just after a rising edge.
// R10: Ready first low on second edge.
// R11: Drive data only while select and read low; dout_oe lags them by one clock.
// R12: Word MSB on bit 15, LSB bit 0.
// R13: In-range words are linear two's complement.
// R14: Range flag updates with each new word.

    localparam int          SDDO_WORD_W        = 16;
    localparam int          SDDO_SAMPLE_W      = 18;
    localparam int          SDDO_DECIM_SLOW    = 8;
    localparam int          SDDO_DECIM_FAST    = 4;
    localparam int          SDDO_SHIFT_SLOW    = 3;
    localparam int          SDDO_SHIFT_FAST    = 2;
    localparam logic [15:0] SDDO_FULL_POS      = 16'h7fff;
    localparam logic [15:0] SDDO_FULL_NEG      = 16'h8000;
    localparam int          SDDO_SETTLE_CYCLES = 47;
    localparam int          SDDO_SETTLE_W      = 6;
    localparam int          SDDO_BUF_DEPTH     = 2;

    localparam int          SDDO_ADDR_W        = 8;
    localparam logic [7:0]  SDDO_OFS_CTRL      = 8'h00;
    localparam logic [7:0]  SDDO_OFS_STATUS    = 8'h04;
    localparam logic [7:0]  SDDO_OFS_DATA      = 8'h08;

    localparam int          SDDO_CTRL_DEC_BIT  = 0;
    localparam int          SDDO_CTRL_CAP_BIT  = 1;
    localparam logic        SDDO_DEC_RESET     = 1'b0;
    localparam logic        SDDO_CAP_RESET     = 1'b0;

    localparam int          SDDO_ST_SETTLED    = 0;
    localparam int          SDDO_ST_RANGE      = 1;
    localparam int          SDDO_ST_BUF        = 2;
    localparam int          SDDO_ST_STALL      = 3;
    localparam int          SDDO_ST_FAST       = 4;
    localparam int          SDDO_ST_COUNT_LSB  = 8;

    localparam int          SDDO_DATA_RANGE    = 16;
    localparam int          SDDO_DATA_VALID    = 31;

    localparam logic [1:0]  SDDO_RESP_OKAY     = 2'b00;
    localparam logic [1:0]  SDDO_RESP_SLVERR   = 2'b10;

    typedef enum logic [0:0] {
        SDDO_BUS_IDLE = 1'b0,
        SDDO_BUS_RESP = 1'b1
    } sddo_bus_state_t;
endpackage

// *** logic/sddo_buf.sv ***
`timescale 1ns/1ps
module sddo_buf
    import sddo_pkg::*;
#(
    parameter int WIDTH = 17,
    parameter int DEPTH = SDDO_BUF_DEPTH
)(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// *** logic/sddo_decim.sv ***
`timescale 1ns/1ps
module sddo_decim
    import sddo_pkg::*;
#(
    parameter int SAMPLE_W = SDDO_SAMPLE_W
)(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       enable,
    input  wire logic                       frame_end,
    input  wire logic                       fast_mode,
    input  wire logic signed [SAMPLE_W-1:0] sample_in,
    output logic [SDDO_WORD_W-1:0]          word,
    output logic                            over_range
);
    localparam int ACC_W = SAMPLE_W + SDDO_SHIFT_SLOW;
    localparam logic signed [ACC_W-1:0] POS_LIM = {{(ACC_W-SDDO_WORD_W){1'b0}}, SDDO_FULL_POS};
    localparam logic signed [ACC_W-1:0] NEG_LIM = {{(ACC_W-SDDO_WORD_W){1'b1}}, SDDO_FULL_NEG};

    logic signed [ACC_W-1:0] acc_reg;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] avg;

    // The sum includes the closing edge's sample, so a frame holds N samples.
    assign sum = acc_reg + ACC_W'(sample_in); // R3
    assign avg = fast_mode ? (sum >>> SDDO_SHIFT_FAST) : (sum >>> SDDO_SHIFT_SLOW); // R1 R2

    always_comb
    begin
        over_range = 1'b0;
        word       = avg[SDDO_WORD_W-1:0]; // R12 R13
        if (avg > POS_LIM)
        begin
            word       = SDDO_FULL_POS; // R4
            over_range = 1'b1; // R6
        end
        else if (avg < NEG_LIM)
        begin
            word       = SDDO_FULL_NEG; // R5
            over_range = 1'b1; // R6
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_reg <= '0;
        end
        else if (enable)
        begin
            acc_reg <= frame_end ? '0 : sum;
        end
    end
endmodule

// *** logic/sddo_top.sv ***
`timescale 1ns/1ps
module sddo_top
    import sddo_pkg::*;
#(
    parameter int SAMPLE_W = SDDO_SAMPLE_W,
    parameter int DEPTH    = SDDO_BUF_DEPTH
)(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic signed [SAMPLE_W-1:0] sample_in,
    input  wire logic                       cs_n,
    input  wire logic                       rd_n,
    output logic [SDDO_WORD_W-1:0]          dout,
    output logic                            dout_oe,
    output logic                            data_ready_n,
    output logic                            range_exceeded_flag,
    input  wire logic [SDDO_ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [SDDO_ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    localparam int BUF_W = SDDO_WORD_W + 1;
    localparam logic [2:0] SLOW_LAST = 3'(SDDO_DECIM_SLOW - 1);
    localparam logic [2:0] FAST_LAST = 3'(SDDO_DECIM_FAST - 1);
    localparam logic [2:0] SLOW_HALF = 3'(SDDO_DECIM_SLOW / 2);
    localparam logic [2:0] FAST_HALF = 3'(SDDO_DECIM_FAST / 2);
    localparam logic [SDDO_SETTLE_W-1:0] SETTLE_LAST = SDDO_SETTLE_W'(SDDO_SETTLE_CYCLES);

    // Control and status state.
    logic                     dec_sel_reg;
    logic                     capture_reg;
    logic                     fast_reg;
    logic                     started_reg;
    logic [2:0]               phase_reg;
    logic [2:0]               phase_next;
    logic [2:0]               phase_last;
    logic [2:0]               phase_half;
    logic                     data_ready_n_reg;
    logic [SDDO_WORD_W-1:0]   dout_reg;
    logic                     dout_oe_reg;
    logic                     range_reg;
    logic [SDDO_SETTLE_W-1:0] settle_cnt_reg;
    logic                     stall_reg;

    // Datapath.
    logic                     frame_edge;
    logic                     stall_now;
    logic [SDDO_WORD_W-1:0]   filt_word;
    logic                     filt_range;
    logic                     buf_in_valid;
    logic                     buf_in_ready;
    logic                     buf_out_valid;
    logic                     buf_out_ready;
    logic [BUF_W-1:0]         buf_out_data;

    // Bus slave state.
    sddo_bus_state_t          wr_state_reg;
    sddo_bus_state_t          rd_state_reg;
    logic                     awready_reg;
    logic                     wready_reg;
    logic                     aw_held_reg;
    logic                     w_held_reg;
    logic [SDDO_ADDR_W-1:0]   awaddr_reg;
    logic [31:0]              wdata_reg;
    logic [3:0]               wstrb_reg;
    logic                     bvalid_reg;
    logic [1:0]               bresp_reg;
    logic                     arready_reg;
    logic                     rvalid_reg;
    logic [1:0]               rresp_reg;
    logic [31:0]              rdata_reg;
    logic [31:0]              rdata_next;
    logic [1:0]               rresp_next;
    logic                     do_write;
    logic                     ar_take;

    assign phase_last = fast_reg ? FAST_LAST : SLOW_LAST; // R1 R2
    assign phase_half = fast_reg ? FAST_HALF : SLOW_HALF;

    // A full buffer holds the frame at its boundary rather than drop a word.
    // Samples arriving during a stall are not integrated.
    assign stall_now  = capture_reg && !buf_in_ready;
    assign frame_edge = started_reg && (phase_reg == '0) && !stall_now;
    assign buf_in_valid = frame_edge && capture_reg;

    always_comb
    begin
        phase_next = phase_reg;
        if (frame_edge)
        begin
            phase_next = 3'h1;
        end
        else if (started_reg && (phase_reg != '0))
        begin
            phase_next = (phase_reg == phase_last) ? 3'h0 : phase_reg + 3'h1;
        end
    end

    sddo_decim #(
        .SAMPLE_W   (SAMPLE_W)
    ) u_decim (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (started_reg && !stall_now),
        .frame_end  (frame_edge),
        .fast_mode  (fast_reg),
        .sample_in  (sample_in),
        .word       (filt_word),
        .over_range (filt_range)
    );

    sddo_buf #(
        .WIDTH      (BUF_W),
        .DEPTH      (DEPTH)
    ) u_buf (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .in_valid   (buf_in_valid),
        .in_ready   (buf_in_ready),
        .in_data    ({filt_range, filt_word}),
        .out_valid  (buf_out_valid),
        .out_ready  (buf_out_ready),
        .out_data   (buf_out_data)
    );

    // The first low phase begins on the second edge after reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            started_reg      <= 1'b0;
            phase_reg        <= '0;
            data_ready_n_reg <= 1'b1; // R8
            fast_reg         <= SDDO_DEC_RESET;
        end
        else
        begin
            started_reg <= 1'b1; // R10
            phase_reg   <= phase_next;
            data_ready_n_reg <= (phase_next == '0) || (phase_next > phase_half); // R10
            if (frame_edge)
            begin
                // A new rate starts only at a frame boundary, so no frame mixes two.
                fast_reg <= dec_sel_reg; // R1 R2
            end
        end
    end

    // Word and range flag change together with the ready falling edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dout_reg  <= '0; // R8
            range_reg <= 1'b0;
        end
        else if (frame_edge)
        begin
            dout_reg  <= filt_word; // R12 R13
            range_reg <= filt_range; // R6 R14
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dout_oe_reg <= 1'b0;
        end
        else
        begin
            dout_oe_reg <= !cs_n && !rd_n; // R11
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            settle_cnt_reg <= '0;
        end
        else if (frame_edge && (settle_cnt_reg != SETTLE_LAST))
        begin
            settle_cnt_reg <= settle_cnt_reg + 1'b1; // R7
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stall_reg <= 1'b0;
        end
        else
        begin
            stall_reg <= started_reg && (phase_reg == '0) && stall_now;
        end
    end

    // Address and data are taken in either order.
    assign do_write = aw_held_reg && w_held_reg && (wr_state_reg == SDDO_BUS_IDLE);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end
        else if (s_axi_awvalid && awready_reg)
        begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held_reg <= 1'b0;
        end
        else if (!aw_held_reg && (wr_state_reg == SDDO_BUS_IDLE))
        begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end
        else if (s_axi_wvalid && wready_reg)
        begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held_reg <= 1'b0;
        end
        else if (!w_held_reg && (wr_state_reg == SDDO_BUS_IDLE))
        begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_reg <= SDDO_BUS_IDLE;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= SDDO_RESP_OKAY;
        end
        else
        begin
            unique case (wr_state_reg)
                SDDO_BUS_IDLE:
                begin
                    if (do_write)
                    begin
                        wr_state_reg <= SDDO_BUS_RESP;
                        bvalid_reg   <= 1'b1;
                        bresp_reg    <= (awaddr_reg == SDDO_OFS_CTRL || awaddr_reg == SDDO_OFS_STATUS ||
                                         awaddr_reg == SDDO_OFS_DATA) ? SDDO_RESP_OKAY : SDDO_RESP_SLVERR;
                    end
                end
                SDDO_BUS_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_reg <= SDDO_BUS_IDLE;
                        bvalid_reg   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Only the control word is writable.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dec_sel_reg <= SDDO_DEC_RESET; // R1
            capture_reg <= SDDO_CAP_RESET;
        end
        else if (do_write && (awaddr_reg == SDDO_OFS_CTRL) && wstrb_reg[0])
        begin
            dec_sel_reg <= wdata_reg[SDDO_CTRL_DEC_BIT]; // R2
            capture_reg <= wdata_reg[SDDO_CTRL_CAP_BIT];
        end
    end

    // Read channel.
    assign ar_take       = s_axi_arvalid && arready_reg;
    assign buf_out_ready = ar_take && (s_axi_araddr == SDDO_OFS_DATA);

    always_comb
    begin
        rdata_next = '0;
        rresp_next = SDDO_RESP_OKAY;
        if (s_axi_araddr == SDDO_OFS_CTRL)
        begin
            rdata_next[SDDO_CTRL_DEC_BIT] = dec_sel_reg;
            rdata_next[SDDO_CTRL_CAP_BIT] = capture_reg;
        end
        else if (s_axi_araddr == SDDO_OFS_STATUS)
        begin
            rdata_next[SDDO_ST_SETTLED] = (settle_cnt_reg == SETTLE_LAST); // R7
            rdata_next[SDDO_ST_RANGE]   = range_reg;
            rdata_next[SDDO_ST_BUF]     = buf_out_valid;
            rdata_next[SDDO_ST_STALL]   = stall_reg;
            rdata_next[SDDO_ST_FAST]    = fast_reg;
            rdata_next[SDDO_ST_COUNT_LSB +: SDDO_SETTLE_W] = settle_cnt_reg;
        end
        else if (s_axi_araddr == SDDO_OFS_DATA)
        begin
            // An empty buffer reads as zero; nothing is popped.
            if (buf_out_valid)
            begin
                rdata_next[SDDO_WORD_W-1:0] = buf_out_data[SDDO_WORD_W-1:0];
                rdata_next[SDDO_DATA_RANGE] = buf_out_data[SDDO_WORD_W];
                rdata_next[SDDO_DATA_VALID] = 1'b1;
            end
        end
        else
        begin
            rresp_next = SDDO_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state_reg <= SDDO_BUS_IDLE;
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= SDDO_RESP_OKAY;
            rdata_reg    <= '0;
        end
        else
        begin
            unique case (rd_state_reg)
                SDDO_BUS_IDLE:
                begin
                    if (ar_take)
                    begin
                        rd_state_reg <= SDDO_BUS_RESP;
                        arready_reg  <= 1'b0;
                        rvalid_reg   <= 1'b1;
                        rdata_reg    <= rdata_next;
                        rresp_reg    <= rresp_next;
                    end
                    else
                    begin
                        arready_reg <= 1'b1;
                    end
                end
                SDDO_BUS_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        rd_state_reg <= SDDO_BUS_IDLE;
                        rvalid_reg   <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign dout                = dout_reg;
    assign dout_oe             = dout_oe_reg;
    assign data_ready_n        = data_ready_n_reg;
    assign range_exceeded_flag = range_reg;
    assign s_axi_awready       = awready_reg;
    assign s_axi_wready        = wready_reg;
    assign s_axi_bvalid        = bvalid_reg;
    assign s_axi_bresp         = bresp_reg;
    assign s_axi_arready       = arready_reg;
    assign s_axi_rvalid        = rvalid_reg;
    assign s_axi_rresp         = rresp_reg;
    assign s_axi_rdata         = rdata_reg;
endmodule

// *** verif/sddo_props.sv ***
`timescale 1ns/1ps
module sddo_props
    import sddo_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic [15:0] dout,
    input wire logic        dout_oe,
    input wire logic        data_ready_n,
    input wire logic        range_exceeded_flag,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready
);
    // Frame checks wait three frames after a control write.
    logic       fast_reg;
    logic       cap_reg;
    logic [1:0] arm_reg;
    wire        wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || wr_ctrl)
        begin
            arm_reg  <= 2'h0;
            fast_reg <= aresetn && s_axi_wdata[SDDO_CTRL_DEC_BIT];
            cap_reg  <= aresetn && s_axi_wdata[SDDO_CTRL_CAP_BIT];
        end
        else if ($fell(data_ready_n) && arm_reg != 2'h3 && !cap_reg)
            arm_reg <= arm_reg + 2'h1;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_slow;
        !data_ready_n[*4] ##1 data_ready_n[*4] ##1 !data_ready_n;
    endsequence
    sequence s_fast;
        !data_ready_n[*2] ##1 data_ready_n[*2] ##1 !data_ready_n;
    endsequence

    a_reset_idle_out: assert property (disable iff (1'b0) !aresetn |=> data_ready_n && dout == 16'h0000)
        else $error("reset outputs wrong");
    a_first_ready_low: assert property ($rose(aresetn) |-> data_ready_n ##1 data_ready_n ##1 !data_ready_n)
        else $error("first ready late");
    a_slow_frame: assert property ($fell(data_ready_n) && arm_reg == 2'h3 && !fast_reg |-> s_slow)
        else $error("slow frame wrong");
    a_fast_frame: assert property ($fell(data_ready_n) && arm_reg == 2'h3 && fast_reg |-> s_fast)
        else $error("fast frame wrong");
    a_bus_release: assert property ((cs_n || rd_n) |=> !dout_oe) else $error("bus not released");
    a_bus_drive: assert property (!cs_n && !rd_n |=> dout_oe) else $error("bus not driven");
    a_word_holds: assert property (!$fell(data_ready_n) |-> $stable(dout) && $stable(range_exceeded_flag))
        else $error("word moved");
    a_flag_full_scale: assert property (range_exceeded_flag |-> dout == SDDO_FULL_POS || dout == SDDO_FULL_NEG)
        else $error("flag without full scale");
endmodule

bind sddo_top sddo_props u_props (.aclk, .aresetn, .cs_n, .rd_n, .dout, .dout_oe, .data_ready_n,
    .range_exceeded_flag, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready);

// *** verif/sddo_host.sv ***
`timescale 1ns/1ps
module sddo_host
    import sddo_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        hold_off,
    input  wire logic        data_ready_n,
    input  wire logic [15:0] dout,
    input  wire logic        dout_oe,
    output logic             cs_n,
    output logic             rd_n,
    output logic [15:0]      word,
    output logic [15:0]      count
);
    logic        data_ready_n_q;
    // A released bus has no pull; it shows the inverse of the last word.
    wire  [15:0] bus = dout_oe ? dout : ~word;

    always_ff @(posedge aclk)
    begin
        data_ready_n_q <= data_ready_n;
        if (!aresetn)
        begin
            cs_n  <= 1'b1;
            rd_n  <= 1'b1;
            word  <= 16'h0000;
            count <= 16'h0000;
        end
        else if (!cs_n && dout_oe)
        begin
            word  <= bus;
            count <= count + 16'h0001;
            cs_n  <= 1'b1;
            rd_n  <= 1'b1;
        end
        else if (data_ready_n_q && !data_ready_n && !hold_off)
        begin
            cs_n <= 1'b0;
            rd_n <= 1'b0;
        end
    end
endmodule

// *** verif/sigma_delta_decimator_output_tb.sv ***
`timescale 1ns/1ps
module sigma_delta_decimator_output_tb
    import sddo_pkg::*;
;
    logic               aclk = 1'b0, aresetn = 1'b0, hold_off = 1'b0;
    logic signed [17:0] sample_in = 18'sh00000;
    logic               cs_n, rd_n, dout_oe, data_ready_n, range_exceeded_flag;
    logic [15:0]        dout, host_word, host_count;
    logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]         s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]         s_axi_wstrb = 4'hf;
    logic [1:0]         s_axi_bresp, s_axi_rresp, r;
    logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int                 errors = 0, checked = 0, cycles = 0;

    sddo_top dut (.aclk, .aresetn, .sample_in, .cs_n, .rd_n, .dout, .dout_oe, .data_ready_n, .range_exceeded_flag,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sddo_host host (.aclk, .aresetn, .hold_off, .data_ready_n, .dout, .dout_oe, .cs_n, .rd_n, .word(host_word),
        .count(host_count));

    task automatic check(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // The third word after a change is wholly new.
    task automatic run(input logic signed [17:0] s, input logic [15:0] w, input logic f);
        sample_in <= s;
        repeat (3) @(host_count);
        check("word", {16'h0, host_word}, {16'h0, w});
        check("flag", {31'h0, range_exceeded_flag}, {31'h0, f});
    endtask

    initial
    begin
        forever #10 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(SDDO_OFS_CTRL);
        check("ctrl", d, 32'h0);
        axi_read(SDDO_OFS_STATUS);
        check("unsettled", d & 32'h1, 32'h0);
        axi_read(8'h0c);
        check("rresp", {30'h0, r}, {30'h0, SDDO_RESP_SLVERR});
        axi_write(8'h10, 32'h0);
        check("bresp", {30'h0, r}, {30'h0, SDDO_RESP_SLVERR});
        sample_in <= 18'sh00123;
        repeat (47) @(host_count);
        axi_read(SDDO_OFS_STATUS);
        check("settle", d & 32'h3f01, 32'h2f01);
        run(18'sh00123, 16'h0123, 1'b0);
        run(18'sh3fffb, 16'hfffb, 1'b0);
        run(18'sh07fff, 16'h7fff, 1'b0);
        run(18'sh0ffff, 16'h7fff, 1'b1);
        run(18'sh2ffff, 16'h8000, 1'b1);
        axi_write(SDDO_OFS_CTRL, 32'h1);
        run(18'sh00123, 16'h0123, 1'b0);
        axi_read(SDDO_OFS_STATUS);
        check("fast", d & 32'h10, 32'h10);
        hold_off <= 1'b1;
        axi_write(SDDO_OFS_CTRL, 32'h2);
        do
            axi_read(SDDO_OFS_STATUS);
        while (d[3] !== 1'b1);
        check("stall", d & 32'h0c, 32'h0c);
        axi_write(SDDO_OFS_CTRL, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            axi_read(SDDO_OFS_DATA);
            check("data", d, i < 2 ? 32'h80000123 : 32'h0);
        end
        hold_off <= 1'b0;
        aresetn  <= 1'b0;
        repeat (4) @(posedge aclk);
        check("reset", {15'h0, data_ready_n, dout}, 32'h10000);
        aresetn <= 1'b1;
        repeat (3) @(host_count);
        check("restart", {16'h0, host_word}, 32'h0123);
        stop_test();
    end
endmodule
